// *** control_port_pin_select_bench.sv ***
// Self-checking bench for the pin selection block
`timescale 1ns/1ps
module control_port_pin_select_bench;
   import cps_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic strap = 1'b0;
   logic drv_low = 1'b0;
   logic tx = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [31:0] seed = 32'he92585e8;
   cps_cfg_s cfg = '0;
   cps_stat_s st;
   logic scl, sel_n, dedicated_data_in_pin, sdo, sdo_oe_n, f1, f1z, f2, f2z, din, rxv;
   logic [7:0] rxb;
   logic [1:0] seen;
   int errors = 0, check_count = 0, cyc = 0, rx_n = 0;
   cps_pin_select dut (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_cfg(cfg),
      .i_tx_bit(tx), .i_i2c_drive_low(drv_low), .i_control_port_select(strap),
      .i_address_bit_zero_pin(addr[0]), .i_address_bit_one_pin(addr[1]),
      .i_address_or_select_pin(strap ? sel_n : addr[2]),
      .i_dedicated_data_in_pin(dedicated_data_in_pin), .i_shared_data_pin(sdo_oe_n | sdo),
      .o_shared_data_pin(sdo), .o_shared_data_pin_oe_n(sdo_oe_n),
      .o_input_one_active_flag_pin(f1), .o_input_one_active_flag_pin_oe_n(f1z),
      .o_input_two_active_flag_pin(f2), .o_input_two_active_flag_pin_oe_n(f2z),
      .o_stat(st), .o_shared_data_in(din), .o_rx_byte(rxb), .o_rx_valid(rxv));
   cps_host_model host (.o_scl(scl), .o_sel_n(sel_n), .o_sdi(dedicated_data_in_pin), .i_sdo(sdo),
      .i_sdo_oe_n(sdo_oe_n), .o_seen(seen));
   initial forever #12.5 clk = ~clk;
   task automatic final_report();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (rxv === 1'b1) rx_n++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rnd();
      @(posedge clk);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      cfg <= cps_cfg_s'(seed[5:0]);
      addr <= seed[8:6];
      tx <= seed[9];
      drv_low <= seed[10];
   endtask
   task automatic do_reset(input logic m);
      @(posedge clk);
      nrst <= 1'b0;
      strap <= m;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic chk_all();
      repeat (8) @(posedge clk);
      #1;
      chk(f1z, !cfg.ind1_en);
      chk(f2z, !cfg.ind2_en);
      if (cfg.ind1_en) chk(f1, (cfg.active_sel == CPS_SEL_IN1) ^ cfg.ind_pol);
      if (cfg.ind2_en) chk(f2, (cfg.active_sel == CPS_SEL_IN2) ^ cfg.ind_pol);
      chk(st.in1_active, cfg.active_sel == CPS_SEL_IN1);
      chk(st.in2_active, cfg.active_sel == CPS_SEL_IN2);
      chk(st.fs_in3_for_in1, cfg.pairing_cfg);
      chk(st.mode_spi, strap);
   endtask
   initial begin
      do_reset(CPS_MODE_I2C);
      for (int i = 0; i < 10; i++) begin
         rnd();
         host.send(seed[18:11], 8);
         chk_all();
         chk(st.i2c_addr, addr);
         chk({sdo_oe_n, sdo}, {!drv_low, 1'b0});
         chk(din, !drv_low);
      end
      chk(rx_n, 0);
      do_reset(CPS_MODE_SPI);
      // Partial byte is cut off by the select release and yields no received byte
      host.send(8'ha5, 5);
      for (int i = 0; i < 6; i++) begin
         rnd();
         host.send(seed[18:11], 8);
         chk_all();
         chk(rxb, seed[18:11]);
         chk(seen, {1'b0, tx});
         chk({sdo_oe_n, st.i2c_addr}, 4'h8);
         chk(din, 1'b0);
      end
      chk(rx_n, 6);
      final_report();
   end
endmodule
bind cps_pin_select cps_pin_select_props u_props (.i_ref_clk, .i_nrst, .i_cfg,
   .i_control_port_select, .i_address_bit_zero_pin, .i_address_bit_one_pin,
   .i_address_or_select_pin, .o_input_one_active_flag_pin,
   .o_input_one_active_flag_pin_oe_n, .o_input_two_active_flag_pin,
   .o_input_two_active_flag_pin_oe_n, .o_stat);

// *** cps_host_model.sv ***
// Behavioural host on the serial control port
`timescale 1ns/1ps
module cps_host_model (
   // Serial lines
   output logic o_scl,
   output logic o_sel_n,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe_n,
   // Pin state seen before the last edge
   output logic [1:0] o_seen
);
   initial begin
      o_scl = 1'b0;
      o_sel_n = 1'b1;
      o_sdi = 1'b0;
      o_seen = 2'h0;
   end
   // Clock stands low between frames
   task automatic send(input logic [7:0] b, input int n);
      o_sel_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         o_sdi = b[7 - i];
         #40;
         o_seen = {i_sdo_oe_n, i_sdo};
         o_scl = 1'b1;
         #40 o_scl = 1'b0;
      end
      #40 o_sel_n = 1'b1;
      o_sdi = ~o_sdi;
   endtask
endmodule

// *** cps_pin_select.sv ***
// Pin function selection and serial link front end for the control port
`timescale 1ns/1ps
module cps_pin_select
   import cps_pkg::*;
(
   // Clocks and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_scl,
   // Configuration and clock-select state from the core
   input wire cps_pkg::cps_cfg_s i_cfg,
   input wire logic i_tx_bit,
   input wire logic i_i2c_drive_low,
   // Pins
   input wire logic i_control_port_select,
   input wire logic i_address_bit_zero_pin,
   input wire logic i_address_bit_one_pin,
   input wire logic i_address_or_select_pin,
   input wire logic i_dedicated_data_in_pin,
   input wire logic i_shared_data_pin,
   output logic o_shared_data_pin,
   output logic o_shared_data_pin_oe_n,
   output logic o_input_one_active_flag_pin,
   output logic o_input_one_active_flag_pin_oe_n,
   output logic o_input_two_active_flag_pin,
   output logic o_input_two_active_flag_pin_oe_n,
   // Status and received data toward the core
   output cps_pkg::cps_stat_s o_stat,
   output logic o_shared_data_in,
   output logic [7:0] o_rx_byte,
   output logic o_rx_valid
);
   import cps_pkg::*;

   // ****************************************************************
   // Reference-domain state
   // ****************************************************************
   typedef struct packed {
      logic       mode_s1;
      logic       mode_s2;
      logic [2:0] addr_s1;
      logic [2:0] addr_s2;
      logic       sda_s1;
      logic       sda_s2;
      logic       tog_s1;
      logic       tog_s2;
      logic       tog_s3;
      logic       warm1;
      logic       warm2;
      cps_stat_s  stat;
      logic       sda_in;
      logic [7:0] rx_byte;
      logic       rx_valid;
      logic       f1;
      logic       f1_oe_n;
      logic       f2;
      logic       f2_oe_n;
   } cps_ref_s;

   // ****************************************************************
   // Link-domain state, clocked by the host serial clock
   // ****************************************************************
   typedef struct packed {
      logic [7:0] shreg;
      logic [7:0] byte_hold;
      logic       tog;
      logic       tx_s1;
      logic       tx_s2;
      logic       drv_s1;
      logic       drv_s2;
      logic       sda;
   } cps_link_s;

   // Per-frame state, cleared whenever the select is released in SPI mode
   typedef struct packed {
      logic [2:0] cnt;
      logic       sda_oe_n;
   } cps_frame_s;

   cps_ref_s r_q;
   cps_ref_s r_d;
   cps_link_s l_q;
   cps_link_s l_d;
   cps_frame_s f_q;
   cps_frame_s f_d;
   logic link_rst_n;

   function automatic logic cps_flag(input logic act, input logic pol);
      cps_flag = act ^ pol;
   endfunction

   // ****************************************************************
   // Reference domain
   // ****************************************************************
   always_comb begin
      r_d = r_q;
      r_d.mode_s1 = i_control_port_select;
      r_d.mode_s2 = r_q.mode_s1;
      r_d.addr_s1 = {i_address_or_select_pin, i_address_bit_one_pin, i_address_bit_zero_pin};
      r_d.addr_s2 = r_q.addr_s1;
      r_d.sda_s1 = i_shared_data_pin;
      r_d.sda_s2 = r_q.sda_s1;
      r_d.tog_s1 = l_q.tog;
      r_d.tog_s2 = r_q.tog_s1;
      r_d.tog_s3 = r_q.tog_s2;
      // Wait until the strap sync holds a real sample, not its reset value
      r_d.warm1 = 1'h1;
      r_d.warm2 = r_q.warm1;
      // Captured once; a strap flip mid-session would corrupt a transfer
      if (r_q.warm2 && !r_q.stat.mode_valid) begin
         r_d.stat.mode_spi = (r_q.mode_s2 == CPS_MODE_SPI);
         r_d.stat.mode_valid = 1'h1;
      end
      if (r_q.stat.mode_spi == CPS_MODE_I2C) begin
         r_d.stat.i2c_addr = r_q.addr_s2;
         r_d.sda_in = r_q.sda_s2;
      end else begin
         r_d.stat.i2c_addr = 3'h0;
         r_d.sda_in = 1'h0;
      end
      r_d.stat.in1_active = (i_cfg.active_sel == CPS_SEL_IN1);
      r_d.stat.in2_active = (i_cfg.active_sel == CPS_SEL_IN2);
      r_d.stat.fs_in3_for_in1 = (i_cfg.pairing_cfg == CPS_PAIR_FS_ON_IN1);
      r_d.f1 = cps_flag(r_d.stat.in1_active, i_cfg.ind_pol);
      r_d.f1_oe_n = (i_cfg.ind1_en != CPS_IND_ENABLED);
      r_d.f2 = cps_flag(r_d.stat.in2_active, i_cfg.ind_pol);
      r_d.f2_oe_n = (i_cfg.ind2_en != CPS_IND_ENABLED);
      r_d.rx_valid = r_q.tog_s2 ^ r_q.tog_s3;
      // Hold word has been stable for at least two ref cycles when the synced toggle lands
      if (r_q.tog_s2 ^ r_q.tog_s3) begin
         r_d.rx_byte = l_q.byte_hold;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r_q <= '0;
         r_q.f1_oe_n <= 1'h1;
         r_q.f2_oe_n <= 1'h1;
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // Link domain
   // ****************************************************************
   // The frame's own select ends it, since the serial clock stops between frames.
   // Mode flop is static after capture, so gating the reset with it is safe.
   assign link_rst_n = i_nrst &
      ~(r_q.stat.mode_spi & (i_address_or_select_pin != CPS_SEL_ASSERTED));

   always_comb begin
      l_d = l_q;
      f_d = f_q;
      l_d.tx_s1 = i_tx_bit;
      l_d.tx_s2 = l_q.tx_s1;
      l_d.drv_s1 = i_i2c_drive_low;
      l_d.drv_s2 = l_q.drv_s1;
      // Mode is static once captured, so the link reads it without a sync
      if (r_q.stat.mode_spi == CPS_MODE_SPI) begin
         l_d.shreg = {l_q.shreg[6:0], i_dedicated_data_in_pin};
         f_d.cnt = f_q.cnt + 3'h1;
         if (f_q.cnt == CPS_CNT_LAST) begin
            l_d.byte_hold = {l_q.shreg[6:0], i_dedicated_data_in_pin};
            l_d.tog = ~l_q.tog;
         end
         l_d.sda = l_q.tx_s2;
         f_d.sda_oe_n = 1'h0;
      end else begin
         f_d.cnt = CPS_CNT_ZERO;
         l_d.sda = 1'h0;
         f_d.sda_oe_n = ~l_q.drv_s2;
      end
   end

   // Toggle and hold word must outlive the select, or the byte is lost
   always_ff @(posedge i_scl or negedge i_nrst) begin
      if (!i_nrst) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   always_ff @(posedge i_scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         f_q <= '0;
         f_q.sda_oe_n <= 1'h1;
      end else begin
         f_q <= f_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_shared_data_pin = l_q.sda;
   assign o_shared_data_pin_oe_n = f_q.sda_oe_n;
   assign o_input_one_active_flag_pin = r_q.f1;
   assign o_input_one_active_flag_pin_oe_n = r_q.f1_oe_n;
   assign o_input_two_active_flag_pin = r_q.f2;
   assign o_input_two_active_flag_pin_oe_n = r_q.f2_oe_n;
   assign o_stat = r_q.stat;
   assign o_shared_data_in = r_q.sda_in;
   assign o_rx_byte = r_q.rx_byte;
   assign o_rx_valid = r_q.rx_valid;

endmodule

// *** cps_pin_select_props.sv ***
// Concurrent checks on the pin selection block
`timescale 1ns/1ps
module cps_pin_select_props
   import cps_pkg::*;
(
   // Clock, reset, inputs
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire cps_pkg::cps_cfg_s i_cfg,
   input wire logic i_control_port_select,
   input wire logic i_address_bit_zero_pin,
   input wire logic i_address_bit_one_pin,
   input wire logic i_address_or_select_pin,
   // Outputs
   input wire logic o_input_one_active_flag_pin,
   input wire logic o_input_one_active_flag_pin_oe_n,
   input wire logic o_input_two_active_flag_pin,
   input wire logic o_input_two_active_flag_pin_oe_n,
   input wire cps_pkg::cps_stat_s o_stat
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   wire logic [2:0] pins = {i_address_or_select_pin, i_address_bit_one_pin,
      i_address_bit_zero_pin};
   wire logic act1 = i_cfg.active_sel == CPS_SEL_IN1;
   wire logic act2 = i_cfg.active_sel == CPS_SEL_IN2;
   wire logic i2c = o_stat.mode_valid && !o_stat.mode_spi;
   // Address pins pass a two-flop sync, so demand a steady stretch
   sequence s_i2c_steady;
      (i2c && $stable(pins))[*5];
   endsequence
   property p_pairing;
      i_nrst |=> o_stat.fs_in3_for_in1 == $past(i_cfg.pairing_cfg);
   endproperty
   a_pairing: assert property (p_pairing) else $error("pairing");
   property p_in1;
      i_nrst |=> o_stat.in1_active == $past(act1);
   endproperty
   a_in1: assert property (p_in1) else $error("in1 status");
   property p_flag1;
      i_nrst |=> o_input_one_active_flag_pin_oe_n == !$past(i_cfg.ind1_en)
         && (!$past(i_cfg.ind1_en)
         || o_input_one_active_flag_pin == $past(act1 ^ i_cfg.ind_pol));
   endproperty
   a_flag1: assert property (p_flag1) else $error("flag one");
   property p_flag2;
      i_nrst |=> o_input_two_active_flag_pin_oe_n == !$past(i_cfg.ind2_en)
         && (!$past(i_cfg.ind2_en)
         || o_input_two_active_flag_pin == $past(act2 ^ i_cfg.ind_pol));
   endproperty
   a_flag2: assert property (p_flag2) else $error("flag two");
   property p_mode_pick;
      $rose(o_stat.mode_valid) |-> o_stat.mode_spi == i_control_port_select;
   endproperty
   a_mode_pick: assert property (p_mode_pick) else $error("mode");
   property p_mode_hold;
      o_stat.mode_valid |=> o_stat.mode_valid && $stable(o_stat.mode_spi);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
   property p_spi_addr;
      o_stat.mode_valid && o_stat.mode_spi |=> o_stat.i2c_addr == 3'h0;
   endproperty
   a_spi_addr: assert property (p_spi_addr) else $error("spi addr");
   property p_i2c_addr;
      s_i2c_steady |-> o_stat.i2c_addr == pins;
   endproperty
   a_i2c_addr: assert property (p_i2c_addr) else $error("i2c addr");
endmodule

// *** cps_pkg.sv ***
// Constants and carrier types for the control-port pin selection block
// ****************************************************************
// What this block does
// - Pairing one makes input three frame sync
// - Input-one active status always kept current
// - Input-one flag pin driven or tristated, polarity
// - Input-two flag pin driven or tristated, polarity
// - Host serial clock clocks the link logic
// - I2C mode: shared data pin is bidirectional
// - SPI mode: shared data pin drives output
// - I2C mode: two low address pins set address
// - SPI mode: two low address pins ignored
// - I2C mode: address/select pin is address bit
// - SPI mode: transfers only under slave select
// - Dedicated data input used only in SPI
// - Select pin zero I2C, one SPI
// ****************************************************************
package cps_pkg;

   // ****************************************************************
   // Encodings and widths
   // ****************************************************************
   localparam logic       CPS_MODE_I2C = 1'h0;
   localparam logic       CPS_MODE_SPI = 1'h1;
   localparam logic       CPS_PAIR_FS_ON_IN1 = 1'h1;
   localparam logic       CPS_IND_ENABLED = 1'h1;
   localparam logic       CPS_SEL_ASSERTED = 1'h0;
   localparam int         CPS_BYTE_W = 8;
   localparam int         CPS_CNT_W = 3;
   localparam logic [2:0] CPS_CNT_LAST = 3'h7;
   localparam logic [2:0] CPS_CNT_ZERO = 3'h0;
   localparam logic [1:0] CPS_SEL_IN1 = 2'h0;
   localparam logic [1:0] CPS_SEL_IN2 = 2'h1;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic [1:0] active_sel;
      logic       pairing_cfg;
      logic       ind1_en;
      logic       ind2_en;
      logic       ind_pol;
   } cps_cfg_s;

   typedef struct packed {
      logic       in1_active;
      logic       in2_active;
      logic       fs_in3_for_in1;
      logic       mode_spi;
      logic       mode_valid;
      logic [2:0] i2c_addr;
   } cps_stat_s;

endpackage
